// >>> rtl/aup_pkg.sv
// Function
// RL1: Modes 0, 1, 2 drive upper pins as parallel result bits 12 to 17.
// RL2: Serial master mode drives a frame marker alongside the internal data clock.
// RL3: Marker polarity low: marker high from read start while serial data valid.
// RL4: Marker polarity high: marker low from read start while serial data valid.
// RL5: Serial slave: unfinished read discards result and pulses the read-error flag high.
// RL6: Serial mode, source select low: range and settings come from serial register.
// RL7: Source select high: settings come from dedicated pins, serial register ignored.
// RL8: Host shifts configuration MSB first; device latches each bit on configuration clock.
// RL9: Edge inversion input chooses which configuration clock edge samples data.
// RL10: Configuration bits accepted only while the port select is active.
// RL11: Busy rises at conversion start, holds until result latched; the code also drops busy when a slave read error discards the result.
// RL12: Host may use busy falling edge as a data-ready strobe.
// RL13: Unsigned range: wide select low gives 0 to 5 V, high gives 0 to 10 V.
// RL14: Edge inversion low uses rising clock edges, high uses falling edges.
// RL15: Reset aborts conversion, zeroes data outputs, clears serial configuration register.
// RL16: Configuration port ignored in parallel modes or with hardware source selected.
package aup_pkg;
   // Widths
   localparam int RES_W = 18;
   localparam int UP_LO = 12;
   localparam int UP_W = 6;
   localparam int CFG_W = 12;
   localparam int CFG_OTHER_W = 10;
   localparam int CFG_SIGNED_BIT = 11;
   localparam int CFG_WIDE_BIT = 10;
   localparam int IRQ_W = 3;
   // Interface modes
   localparam logic [1:0] MODE_SERIAL = 2'h3;
   // Upper pin positions
   localparam int PIN_MARKER = 0;
   localparam int PIN_RDERR = 1;
   // Interrupt bit positions
   localparam int IRQ_CONV_DONE = 0;
   localparam int IRQ_READ_ERR = 1;
   localparam int IRQ_CFG_LOAD = 2;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
   localparam logic [7:0] REG_IRQ_EN = 8'h10;
   localparam logic [7:0] REG_CFG = 8'h14;
   localparam logic [7:0] REG_RESULT = 8'h18;
   localparam int CTRL_HOLD_BIT = 0;
   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // Timing: read-error pulse width
   localparam int CLK_PERIOD_NS = 100;
   localparam int ERR_PULSE_NS = 200;
   localparam int ERR_PULSE_CYC_I = (ERR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] ERR_PULSE_CYC = 2'(ERR_PULSE_CYC_I);
   localparam logic [3:0] CFG_W_CNT = 4'(CFG_W);

   // Pin levels from outside the clock domain
   typedef struct packed {
      logic [1:0] mode;
      logic clock_source_select;
      logic frame_marker_polarity;
      logic config_source_select;
      logic cfg_serial_in;
      logic cfg_serial_clock;
      logic cfg_port_select_b;
      logic serial_edge_invert;
      logic wide_range_select;
      logic signed_range_select;
   } aup_pins_t;

   // Active input range
   typedef struct packed {
      logic signed_sel;
      logic wide_sel;
   } aup_range_t;

   // Whole block state
   typedef struct packed {
      aup_pins_t s1;
      aup_pins_t s2;
      logic clk_prev;
      logic sel_prev_b;
      logic [CFG_W-1:0] shift;
      logic [3:0] bit_cnt;
      logic [CFG_W-1:0] cfg;
      logic busy;
      logic [RES_W-1:0] result;
      logic rd_open;
      logic [1:0] err_cnt;
      logic hold;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } aup_state_t;
endpackage

// >>> rtl/aup_upper_pins.sv
`timescale 1ns/100ps
module aup_upper_pins import aup_pkg::*; (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // Mode and configuration pins (asynchronous)
   input wire logic [1:0] mode_in,
   input wire logic clock_source_select_in,
   input wire logic frame_marker_polarity_in,
   input wire logic config_source_select_in,
   input wire logic cfg_serial_in,
   input wire logic cfg_serial_clock_in,
   input wire logic cfg_port_select_b_in,
   input wire logic serial_edge_invert_in,
   input wire logic wide_range_select_in,
   input wire logic signed_range_select_in,
   // Converter core events (same clock)
   input wire logic conv_start_in,
   input wire logic conv_done_in,
   input wire logic [RES_W-1:0] conv_result_in,
   input wire logic read_seq_active_in,
   input wire logic slave_read_start_in,
   input wire logic slave_read_done_in,
   // Upper pins and status
   output logic [UP_W-1:0] upper_pin_out,
   output logic [UP_W-1:0] upper_pin_oe_out,
   output logic conv_busy_out,
   output aup_range_t range_out,
   output logic [CFG_OTHER_W-1:0] cfg_settings_out,
   output logic result_discard_out,
   output logic irq_out,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);

   aup_state_t q;
   aup_state_t d;
   aup_pins_t pins_raw;
   logic serial;
   logic master;
   logic slave;
   logic use_sw;
   logic port_en;
   logic clk_rise;
   logic clk_fall;
   logic cfg_edge;
   logic sel_release;
   logic start_ok;
   logic read_err;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] clr;
   logic addr_ok;
   logic [31:0] rd_mux;

   // Gather pin levels for the synchroniser
   assign pins_raw = '{mode: mode_in,
                       clock_source_select: clock_source_select_in,
                       frame_marker_polarity: frame_marker_polarity_in,
                       config_source_select: config_source_select_in,
                       cfg_serial_in: cfg_serial_in,
                       cfg_serial_clock: cfg_serial_clock_in,
                       cfg_port_select_b: cfg_port_select_b_in,
                       serial_edge_invert: serial_edge_invert_in,
                       wide_range_select: wide_range_select_in,
                       signed_range_select: signed_range_select_in};

   // Mode decode from synchronised pins
   assign serial = (q.s2.mode == MODE_SERIAL);
   assign master = serial && !q.s2.clock_source_select; // RL2
   assign slave = serial && q.s2.clock_source_select;
   assign use_sw = serial && !q.s2.config_source_select; // RL6 RL7
   // Port dead in parallel modes or hardware source
   assign port_en = use_sw && !q.s2.cfg_port_select_b; // RL10 RL16

   // Configuration clock edges, seen by the system clock
   assign clk_rise = q.s2.cfg_serial_clock && !q.clk_prev;
   assign clk_fall = !q.s2.cfg_serial_clock && q.clk_prev;
   assign cfg_edge = q.s2.serial_edge_invert ? clk_fall : clk_rise; // RL9 RL14
   assign sel_release = q.s2.cfg_port_select_b && !q.sel_prev_b;

   // Conversion bookkeeping
   assign start_ok = conv_start_in && !q.hold;
   // A slave read still open when the next result lands is lost
   assign read_err = slave && q.rd_open && conv_done_in && !slave_read_done_in; // RL5

   // AHB address phase qualifier
   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
   assign clr = (q.wr_pend && q.wr_addr == REG_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;

   // Read data for the address phase
   always_comb begin
      rd_mux = '0;
      unique case (haddr[7:0])
         REG_CTRL: rd_mux[CTRL_HOLD_BIT] = q.hold;
         REG_STATUS: rd_mux = {20'h00000, q.err_cnt != '0, q.rd_open, master, slave,
                               use_sw, q.s2.mode, range_out.signed_sel, range_out.wide_sel,
                               q.busy, q.bit_cnt == CFG_W_CNT, serial};
         REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = q.irq_stat;
         REG_IRQ_EN: rd_mux[IRQ_W-1:0] = q.irq_en;
         REG_CFG: rd_mux[CFG_W-1:0] = q.cfg;
         REG_RESULT: rd_mux[RES_W-1:0] = q.result;
         default: rd_mux = '0;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      d = q;
      ev = '0;
      // Two-stage synchroniser on every pin
      d.s1 = pins_raw;
      d.s2 = q.s1;
      d.clk_prev = q.s2.cfg_serial_clock;
      d.sel_prev_b = q.s2.cfg_port_select_b;

      // Configuration shifter, MSB first
      if (!port_en) begin
         d.bit_cnt = '0;
      end else if (cfg_edge) begin
         d.shift = {q.shift[CFG_W-2:0], q.s2.cfg_serial_in}; // RL8
         if (q.bit_cnt != 4'hF) begin
            d.bit_cnt = q.bit_cnt + 4'h1;
         end
      end
      // Frame commits on select release; short or long frames are dropped
      if (use_sw && sel_release && q.bit_cnt == CFG_W_CNT) begin
         d.cfg = q.shift; // RL8
         ev[IRQ_CFG_LOAD] = 1'b1;
      end

      // Busy from start to conversion done, whether the result is latched or discarded
      if (conv_done_in) begin
         d.busy = 1'b0; // RL11
         if (!read_err) begin
            d.result = conv_result_in;
            ev[IRQ_CONV_DONE] = 1'b1;
         end
      end
      if (start_ok) begin
         d.busy = 1'b1; // RL11
      end

      // Slave read tracking and error pulse
      if (read_err) begin
         d.rd_open = 1'b0;
         d.err_cnt = ERR_PULSE_CYC; // RL5
         ev[IRQ_READ_ERR] = 1'b1;
      end else if (slave_read_done_in || !slave) begin
         d.rd_open = 1'b0;
      end else if (slave_read_start_in) begin
         d.rd_open = 1'b1;
      end
      if (!read_err && q.err_cnt != '0) begin
         d.err_cnt = q.err_cnt - 2'h1;
      end

      // Register writes in the data phase
      d.wr_pend = addr_ok && hwrite;
      d.wr_addr = haddr[7:0];
      d.rdata = (addr_ok && !hwrite) ? rd_mux : q.rdata;
      if (q.wr_pend) begin
         unique case (q.wr_addr)
            REG_CTRL: d.hold = hwdata[CTRL_HOLD_BIT];
            REG_IRQ_EN: d.irq_en = hwdata[IRQ_W-1:0];
            default: d.hold = q.hold;
         endcase
      end
      // New events win over a clear in the same cycle
      d.irq_stat = (q.irq_stat & ~clr) | ev;
   end

   // State register; reset clears config and result, aborts conversion
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0; // RL15
      end else begin
         q <= d;
      end
   end

   // Effective range from serial register or dedicated pins
   always_comb begin
      if (use_sw) begin
         range_out.signed_sel = q.cfg[CFG_SIGNED_BIT]; // RL6
         range_out.wide_sel = q.cfg[CFG_WIDE_BIT];
         cfg_settings_out = q.cfg[CFG_OTHER_W-1:0];
      end else begin
         range_out.signed_sel = q.s2.signed_range_select; // RL7
         range_out.wide_sel = q.s2.wide_range_select; // RL13
         cfg_settings_out = '0;
      end
   end

   // Upper pin drive per interface mode
   always_comb begin
      upper_pin_out = '0;
      upper_pin_oe_out = '0;
      if (!serial) begin
         upper_pin_out = q.result[UP_LO +: UP_W]; // RL1
         upper_pin_oe_out = '1;
      end else if (master) begin
         // Marker is active level while a read is running
         upper_pin_out[PIN_MARKER] = read_seq_active_in ^ q.s2.frame_marker_polarity; // RL3 RL4
         upper_pin_oe_out[PIN_MARKER] = 1'b1; // RL2
      end else begin
         upper_pin_out[PIN_RDERR] = q.err_cnt != '0; // RL5
         upper_pin_oe_out[PIN_RDERR] = 1'b1;
      end
   end

   // Remaining outputs
   assign conv_busy_out = q.busy; // RL12
   assign result_discard_out = read_err;
   assign irq_out = |(q.irq_stat & q.irq_en);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;

   // Parallel modes mirror the stored upper result bits
   AST_PAR_BITS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      q.s2.mode != MODE_SERIAL |-> upper_pin_out == q.result[17:12] && &upper_pin_oe_out)
      else $error("upper pins do not carry result bits"); // RL1
   // Marker driven only in master serial mode
   AST_MARKER_OE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      q.s2.mode == MODE_SERIAL |-> upper_pin_oe_out[PIN_MARKER] == !q.s2.clock_source_select)
      else $error("marker enable wrong"); // RL2
   // Marker level for normal polarity
   AST_MARKER_LOW_POL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      master && !q.s2.frame_marker_polarity |-> upper_pin_out[0] == read_seq_active_in)
      else $error("marker not high during read"); // RL3
   // Marker level for inverted polarity
   AST_MARKER_HIGH_POL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      master && q.s2.frame_marker_polarity |-> upper_pin_out[0] == !read_seq_active_in)
      else $error("marker not low during read"); // RL4
   // Lost read gives a two-cycle error pulse and no new result
   AST_READ_ERR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      read_err && !start_ok |=> $stable(q.result) ##0 (q.err_cnt != 2'h0) [*2])
      else $error("read error pulse wrong"); // RL5
   // Serial register drives range when software source selected
   AST_SW_RANGE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      use_sw |-> range_out.wide_sel == q.cfg[10] && range_out.signed_sel == q.cfg[11])
      else $error("software range not used"); // RL6
   // Pin drives wide range select otherwise
   AST_HW_RANGE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !use_sw |-> range_out.wide_sel == q.s2.wide_range_select)
      else $error("hardware range not used"); // RL7 RL13
   // Each accepted edge shifts the sampled bit in at the bottom
   AST_SHIFT_MSB: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      port_en && cfg_edge |=> q.shift == {$past(q.shift[10:0]), $past(q.s2.cfg_serial_in)})
      else $error("config shift wrong"); // RL8
   // Inversion high: a rising configuration clock edge does not shift
   AST_EDGE_SEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      port_en && q.s2.serial_edge_invert && clk_rise |=> $stable(q.shift))
      else $error("wrong config clock edge"); // RL9 RL14
   // Port ignored when deselected or hardware configured
   AST_PORT_OFF: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !port_en |=> q.bit_cnt == 4'h0 && $stable(q.shift))
      else $error("config port not ignored"); // RL10 RL16
   // Busy spans start to done
   AST_BUSY: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      start_ok |=> q.busy)
      else $error("busy not raised"); // RL11
   // Busy only drops on a completed conversion
   AST_BUSY_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      q.busy && !conv_done_in |=> q.busy)
      else $error("busy dropped early"); // RL11
   // Completed conversion latches result and clears busy
   AST_DONE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      conv_done_in && !start_ok && !read_err |=> !q.busy && q.result == $past(conv_result_in))
      else $error("result not latched"); // RL11 RL12

endmodule // aup_upper_pins

// >>> test/aup_cfg_host.sv
`timescale 1ns/100ps
module aup_cfg_host (
   // Configuration port pins of the host
   output logic sclk_out,
   output logic sdata_out,
   output logic sel_b_out
);
   // Idle: clock stands still, port released
   initial begin
      sclk_out = 1'b0;
      sdata_out = 1'b0;
      sel_b_out = 1'b1;
   end
   // Shift n bits MSB first, active edge mid-period, 800 ns per bit
   task automatic send(input logic [11:0] bits, input int n, input logic inv, input logic sel);
      int i;
      sclk_out = inv;
      #400;
      sel_b_out = ~sel;
      for (i = n - 1; i >= 0; i--) begin
         sdata_out = bits[i];
         #400;
         sclk_out = ~inv;
         #400;
         sclk_out = inv;
      end
      #400;
      sel_b_out = 1'b1;
      sdata_out = ~sdata_out; // Released line must not keep a stale bit
   endtask
endmodule // aup_cfg_host

// >>> test/test_aup_upper_pins.sv
`timescale 1ns/100ps
module test_aup_upper_pins import aup_pkg::*; ;
   logic mclk_in = 0, rst_b_in = 0, csrc = 0, pol = 0, hwsrc = 1, inv = 0, wide = 0, sgn = 0;
   logic start = 0, done = 0, rd_act = 0, s_start = 0, s_done = 0;
   logic [1:0] mode_in = 0;
   logic [RES_W-1:0] res = 0, v, held;
   logic [UP_W-1:0] pins, oe;
   logic busy, disc, irq, hro, hresp, hsel = 0, hwrite = 0;
   aup_range_t rng;
   logic [CFG_OTHER_W-1:0] sets;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [11:0] cfgv;
   wire sclk, sdat, ssel_b;
   int err_count = 0, checks_done = 0, cyc = 0, i, k;
   integer seed = 32'h18e4956e;
   aup_upper_pins uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .mode_in(mode_in),
      .clock_source_select_in(csrc), .frame_marker_polarity_in(pol),
      .config_source_select_in(hwsrc), .cfg_serial_in(sdat), .cfg_serial_clock_in(sclk),
      .cfg_port_select_b_in(ssel_b), .serial_edge_invert_in(inv), .wide_range_select_in(wide),
      .signed_range_select_in(sgn), .conv_start_in(start), .conv_done_in(done),
      .conv_result_in(res), .read_seq_active_in(rd_act), .slave_read_start_in(s_start),
      .slave_read_done_in(s_done), .upper_pin_out(pins), .upper_pin_oe_out(oe),
      .conv_busy_out(busy), .range_out(rng), .cfg_settings_out(sets),
      .result_discard_out(disc), .irq_out(irq), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hro),
      .hreadyout(hro), .hresp(hresp), .hrdata(hrdata));
   aup_cfg_host host (.sclk_out(sclk), .sdata_out(sdat), .sel_b_out(ssel_b));
   // Clock, 100 ns period
   initial begin
      forever #50 mclk_in = ~mclk_in;
   end
   // Hang guard, well above the expected run length
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   // One single word transfer; waits on hready, data taken at the second edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge mclk_in); while (hro !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk_in); while (hro !== 1'b1);
      rd = hrdata;
      #1;
      chk(hresp, 0);
   endtask
   // Start, hold busy, finish; d is the expected discard strobe
   task automatic conv(input logic [RES_W-1:0] val, input logic d);
      start <= 1'b1;
      step(1);
      start <= 1'b0;
      chk(busy, 1);
      step(2);
      res <= val;
      done <= 1'b1;
      #1;
      chk(disc, d);
      step(1);
      done <= 1'b0;
      chk(busy, 0);
   endtask
   initial begin
      repeat (8) @(posedge mclk_in);
      chk({oe, pins, busy, irq}, 32'h3F00);
      rst_b_in <= 1'b1;
      step(3);
      bus(1, REG_IRQ_EN, 32'h7);
      // Parallel modes with random results
      for (i = 0; i < 6; i++) begin
         mode_in <= 2'({$random(seed)} % 3);
         v = RES_W'($random(seed));
         step(4);
         conv(v, 0);
         chk({oe, pins}, {6'h3F, v[17:12]});
         chk(irq, 1);
         bus(0, REG_RESULT, 0);
         chk(rd, {14'h0, v});
         bus(1, REG_IRQ_CLR, 32'h1);
         chk(irq, 0);
      end
      // Masking keeps the line low
      conv(18'h3FFFF, 0);
      bus(1, REG_IRQ_EN, 32'h0);
      chk(irq, 0);
      bus(1, REG_IRQ_EN, 32'h7);
      chk(irq, 1);
      bus(1, REG_IRQ_CLR, 32'h7);
      // Hold bit blocks a conversion start
      bus(1, REG_CTRL, 32'h1);
      start <= 1'b1;
      step(1);
      start <= 1'b0;
      chk(busy, 0);
      bus(0, REG_CTRL, 0);
      chk(rd, 32'h1);
      bus(1, REG_CTRL, 32'h0);
      // Slave: conversion ends inside an open read
      mode_in <= MODE_SERIAL;
      csrc <= 1'b1;
      step(4);
      chk(oe[5:2], 0);
      held = 18'h3FFFF;
      s_start <= 1'b1;
      step(1);
      s_start <= 1'b0;
      conv(18'h00123, 1);
      chk(pins[1], 1);
      step(1);
      chk(pins[1], 1);
      step(1);
      chk(pins[1], 0);
      bus(0, REG_RESULT, 0);
      chk(rd, {14'h0, held});
      bus(0, REG_IRQ_STAT, 0);
      chk(rd[1], 1);
      s_done <= 1'b1;
      step(1);
      s_done <= 1'b0;
      conv(18'h00456, 0);
      // Master: frame marker level for both polarities
      csrc <= 1'b0;
      for (i = 0; i < 4; i++) begin
         pol <= i[1];
         rd_act <= i[0];
         step(4);
         chk(pins[0], i[1] ^ i[0]);
      end
      rd_act <= 1'b0;
      // Software configuration on either clock edge
      hwsrc <= 1'b0;
      for (k = 0; k < 2; k++) begin
         inv <= k[0];
         cfgv = 12'($random(seed));
         step(4);
         host.send(cfgv, 12, k[0], 1);
         step(6);
         chk(rng, cfgv[11:10]);
         chk(sets, cfgv[9:0]);
         host.send(~cfgv, 11, k[0], 1);
         host.send(~cfgv, 12, k[0], 0);
         step(6);
         bus(0, REG_CFG, 0);
         chk(rd, {20'h0, cfgv});
      end
      bus(0, REG_IRQ_STAT, 0);
      chk(rd[2], 1);
      // Hardware source: range from pins in all four combinations
      hwsrc <= 1'b1;
      for (i = 0; i < 4; i++) begin
         {sgn, wide} <= i[1:0];
         step(4);
         chk({rng, sets}, {i[1:0], 10'h0});
      end
      // Port ignored with hardware source and in parallel mode
      host.send(~cfgv, 12, 1, 1);
      mode_in <= 2'h0;
      hwsrc <= 1'b0;
      step(4);
      host.send(~cfgv, 12, 1, 1);
      step(6);
      bus(0, REG_CFG, 0);
      chk(rd, {20'h0, cfgv});
      bus(0, 8'h40, 0);
      chk(rd, 0);
      // Reset in mid-conversion
      start <= 1'b1;
      step(1);
      start <= 1'b0;
      rst_b_in <= 1'b0;
      #1;
      chk({busy, pins, irq}, 0);
      step(2);
      rst_b_in <= 1'b1;
      step(3);
      bus(0, REG_CFG, 0);
      chk(rd, 0);
      // Parallel mode after reset: only the two range pins show
      bus(0, REG_STATUS, 0);
      chk(rd, 32'h18);
      summarize();
   end
endmodule // test_aup_upper_pins
